/* File: clkgen_cfg.svh */
// clkgen_cfg.svh: register map, reset values and field positions
// assumes: included by the package and by the register bank module
`ifndef CLKGEN_CFG_SVH
`define CLKGEN_CFG_SVH
// ==========================================
// register map
`define NUM_REGS 19
`define ADDR_MODE 8'h00
`define ADDR_CFGSEL 8'h01
`define ADDR_OSUS_EN 8'h02
`define ADDR_OFORCE 8'h03
`define ADDR_PLLSUS 8'h04
`define ADDR_REFSRC 8'h05
`define ADDR_RSV6 8'h06
`define ADDR_TRIM 8'h07
`define ADDR_RSV8 8'h08
`define ADDR_RSV9 8'h09
`define ADDR_LOOP4 8'h0A
`define ADDR_LOOP5 8'h0B
`define ADDR_LOOP0 8'h0C
`define ADDR_LOOP1 8'h0D
`define ADDR_LOOP2 8'h0E
`define ADDR_LOOP3 8'h0F
`define ADDR_DIV0 8'h10
`define ADDR_DIV1 8'h11
`define ADDR_DIV2 8'h12
`define NUM_REF_DIV 3'h3
// ==========================================
// reset values and writable masks
`define RST_MODE 8'h00
`define MASK_MODE 8'h01
`define RST_CFGSEL 8'h00
`define MASK_CFGSEL 8'h07
`define RST_OSUS_EN 8'h02
`define MASK_OSUS_EN 8'hFF
`define RST_OFORCE 8'h02
`define MASK_OFORCE 8'h7F
`define RST_PLLSUS 8'h0F
`define MASK_PLLSUS 8'h8F
`define RST_REFSRC 8'h04
`define MASK_REFSRC 8'h04
`define RST_TRIM 8'h00
`define MASK_TRIM 8'h1F
`define RST_LOOP 8'h10
`define MASK_LOOP 8'hFF
`define RST_DIV 8'h00
`define MASK_DIV 8'h7F
// ==========================================
// field positions
`define MODE_BIT 0
`define SEL_MSB 2
`define SHDN_BIT 7
`define PSUS_MSB 3
`define REFSRC_BIT 2
`define TRIM_MSB 4
`define DIV_MSB 6
`define CZ_BIT 7
`define IP_MSB 6
`define IP_LSB 4
`define RZ_MSB 3
`define NUM_OUT 7
// bus address of the bank; value is arbitrary
`define DEV_ADDR 7'h5A
`endif

/* File: clkgen_config_bank.sv */
// clkgen_config_bank: configuration registers of the clock generator
// assumes: two-wire serial management port on open-drain pins,
// pins driven from outside the clock domain, synchronous reset.
`timescale 1ns/1ps
`include "clkgen_cfg.svh"
module clkgen_config_bank (
	input wire logic I_CLOCK, // 200 MHz system clock
	input wire logic I_RST, // synchronous reset, high
	input wire logic I_CE, // clock enable, freezes state
	input wire logic I_SCL, // serial clock pin
	input wire logic I_SDA, // serial data pin level
	output logic O_SDA, // serial data drive value
	output logic O_SDA_OE, // serial data drive enable
	input wire clkgen_pkg::cfg_sel_t I_CFG_SEL_PINS, // select pins
	input wire logic I_SHUTDOWN_ENABLE_PIN, // shutdown/enable pin
	input wire logic [6:0] I_OUTPUT_DISABLE_STYLE, // 1 float, 0 low
	output logic O_USE_SW_SELECT, // register selects config
	output clkgen_pkg::cfg_sel_t O_ACTIVE_CONFIG, // config in use
	output logic [6:0] O_OUTPUT_SUSPEND, // per-output suspend
	output logic [6:0] O_OUTPUT_TRISTATE, // suspended and floated
	output logic [3:0] O_PLL_SUSPEND, // per-pll suspend
	output logic O_SHUTDOWN, // full shutdown active
	output logic O_REF_FROM_INPUT_CLOCK, // 1 input clock, 0 crystal
	output logic [4:0] O_CRYSTAL_TRIM, // crystal load trim
	output logic O_PLL_A_ZERO_CAP, // loop filter zero cap
	output logic [2:0] O_PLL_A_PUMP_CURRENT, // charge pump current
	output logic [3:0] O_PLL_A_ZERO_RES, // loop filter zero res
	output logic [6:0] O_PLL_A_REF_DIV, // reference divider
	output logic O_PLL_A_POWER_DOWN // pll A powered down
);
	import clkgen_pkg::*;

	typedef struct packed {
		link_state_e st;
		logic [3:0] bit_cnt;
		reg_t shreg;
		reg_t ptr;
		logic rw;
		logic nack;
		logic scl_prev;
		logic sda_prev;
		logic sda_oe;
		logic sda_out;
		logic [`NUM_REGS-1:0][7:0] regs;
		logic use_sw;
		cfg_sel_t active_cfg;
		logic [3:0] pll_suspend;
		logic shutdown;
		logic ref_clk;
		logic [4:0] trim;
		logic zero_cap;
		logic [2:0] pump;
		logic [3:0] zero_res;
		logic [6:0] ref_div;
		logic pll_a_pd;
	} bank_state_s;

	bank_state_s s;
	bank_state_s next_s;
	logic [5:0] pins;
	logic scl;
	logic sda;
	cfg_sel_t sel_pins;
	logic pin_req;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	cfg_sel_t next_cfg;
	reg_t loop_set;
	reg_t div_set;
	reg_t rd_data;
	logic [15:0] info;
	logic full_sd;
	logic [6:0] sus;
	logic [6:0] tri_st;

	// ==========================================
	// register layout: {writable mask, reset value}
	function automatic logic [15:0] reg_info(input reg_t a);
		case (a)
			`ADDR_MODE: reg_info = {`MASK_MODE, `RST_MODE};
			`ADDR_CFGSEL: reg_info = {`MASK_CFGSEL, `RST_CFGSEL};
			`ADDR_OSUS_EN: reg_info = {`MASK_OSUS_EN, `RST_OSUS_EN};
			`ADDR_OFORCE: reg_info = {`MASK_OFORCE, `RST_OFORCE};
			`ADDR_PLLSUS: reg_info = {`MASK_PLLSUS, `RST_PLLSUS};
			`ADDR_REFSRC: reg_info = {`MASK_REFSRC, `RST_REFSRC};
			`ADDR_TRIM: reg_info = {`MASK_TRIM, `RST_TRIM};
			`ADDR_LOOP4, `ADDR_LOOP5, `ADDR_LOOP0, `ADDR_LOOP1,
			`ADDR_LOOP2, `ADDR_LOOP3: reg_info = {`MASK_LOOP, `RST_LOOP};
			`ADDR_DIV0, `ADDR_DIV1,
			`ADDR_DIV2: reg_info = {`MASK_DIV, `RST_DIV};
			// reserved and unmapped: nothing writable
			default: reg_info = 16'h0000;
		endcase
	endfunction : reg_info

	function automatic bank_state_s reset_state();
		bank_state_s r;
		r = '0;
		for (int i = 0; i < `NUM_REGS; i++) begin
			r.regs[i] = reg_t'(reg_info(8'(i)));
		end
		r.st = ST_IDLE;
		r.scl_prev = 1'b1;
		r.sda_prev = 1'b1;
		r.pll_a_pd = 1'b1;
		return r;
	endfunction : reset_state

	// ==========================================
	// pin synchronisers
	pin_sync #(
		.WIDTH(6)
	) u_sync (
		.i_clock(I_CLOCK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_async({I_SHUTDOWN_ENABLE_PIN, I_CFG_SEL_PINS, I_SDA, I_SCL}),
		.o_sync(pins)
	);
	assign scl = pins[0];
	assign sda = pins[1];
	assign sel_pins = pins[4:2];
	assign pin_req = pins[5];
	assign full_sd = s.regs[`ADDR_PLLSUS][`SHDN_BIT];

	// ==========================================
	// serial port and register access
	always_comb begin
		next_s = s;
		scl_rise = scl & ~s.scl_prev;
		scl_fall = ~scl & s.scl_prev;
		start = scl & s.scl_prev & s.sda_prev & ~sda;
		stop = scl & s.scl_prev & ~s.sda_prev & sda;
		rd_data = (s.ptr < `NUM_REGS) ? s.regs[s.ptr[4:0]] : 8'h00;
		info = reg_info(s.ptr);
		next_s.scl_prev = scl;
		next_s.sda_prev = sda;
		if (scl_rise) begin
			next_s.shreg = {s.shreg[6:0], sda};
			next_s.bit_cnt = s.bit_cnt + 4'h1;
		end
		if (stop) begin
			next_s.st = ST_IDLE;
			next_s.sda_oe = 1'b0;
		end else if (start) begin
			next_s.st = ST_ADDR;
			next_s.bit_cnt = 4'h0;
			next_s.sda_oe = 1'b0;
		end else if (scl_fall) begin
			case (s.st)
				ST_ADDR: begin
					if (s.bit_cnt == 4'h8) begin
						if (s.shreg[7:1] == `DEV_ADDR) begin
							next_s.rw = s.shreg[0];
							next_s.sda_oe = 1'b1;
							next_s.st = ST_ADDR_ACK;
						end else begin
							next_s.st = ST_IGNORE;
						end
					end
				end
				ST_PTR: begin
					if (s.bit_cnt == 4'h8) begin
						next_s.ptr = s.shreg;
						next_s.sda_oe = 1'b1;
						next_s.st = ST_PTR_ACK;
					end
				end
				ST_WDATA: begin
					if (s.bit_cnt == 4'h8) begin
						// masked write keeps reserved bits at zero
						next_s.regs[s.ptr[4:0]] = (s.shreg & info[15:8]) |
							(rd_data & ~info[15:8]);
						if (s.ptr >= `NUM_REGS) begin
							next_s.regs = s.regs;
						end
						next_s.ptr = s.ptr + 8'h01;
						next_s.sda_oe = 1'b1;
						next_s.st = ST_WDATA_ACK;
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK: begin
					next_s.sda_oe = 1'b0;
					next_s.bit_cnt = 4'h0;
					next_s.st = ST_WDATA;
				end
				ST_ADDR_ACK, ST_RDATA_ACK: begin
					next_s.bit_cnt = 4'h0;
					if (s.st == ST_ADDR_ACK && !s.rw) begin
						next_s.sda_oe = 1'b0;
						next_s.st = ST_PTR;
					end else if (s.st == ST_RDATA_ACK && s.nack) begin
						next_s.sda_oe = 1'b0;
						next_s.st = ST_IGNORE;
					end else begin
						// open-drain: pull low to send a zero
						next_s.shreg = rd_data;
						next_s.sda_oe = ~rd_data[7];
						next_s.ptr = s.ptr + 8'h01;
						next_s.st = ST_RDATA;
					end
				end
				ST_RDATA: begin
					if (s.bit_cnt == 4'h8) begin
						next_s.sda_oe = 1'b0;
						next_s.st = ST_RDATA_ACK;
					end else begin
						next_s.shreg = {s.shreg[6:0], 1'b0};
						next_s.sda_oe = ~s.shreg[6];
					end
				end
				default: begin
					next_s.st = s.st;
				end
			endcase
		end
		// read shift must not eat the sampled bus bit
		if (scl_rise && s.st == ST_RDATA) begin
			next_s.shreg = s.shreg;
		end
		if (scl_rise && s.st == ST_RDATA_ACK) begin
			next_s.nack = sda;
		end

		// ==========================================
		// configuration decode
		next_s.use_sw = s.regs[`ADDR_MODE][`MODE_BIT];
		next_cfg = next_s.use_sw ? s.regs[`ADDR_CFGSEL][`SEL_MSB:0] :
			sel_pins;
		next_s.active_cfg = next_cfg;
		case (next_cfg)
			3'h4: loop_set = s.regs[`ADDR_LOOP4];
			3'h5: loop_set = s.regs[`ADDR_LOOP5];
			3'h6, 3'h7: loop_set = s.regs[`ADDR_LOOP0];
			default: loop_set = s.regs[`ADDR_LOOP0 + {3'h0, next_cfg[1:0]}];
		endcase
		// sets without their own divider fall back to set 0
		if (next_cfg < `NUM_REF_DIV) begin
			div_set = s.regs[`ADDR_DIV0 + {5'h00, next_cfg}];
		end else begin
			div_set = s.regs[`ADDR_DIV0];
		end
		next_s.zero_cap = loop_set[`CZ_BIT];
		next_s.pump = loop_set[`IP_MSB:`IP_LSB];
		next_s.zero_res = loop_set[`RZ_MSB:0];
		next_s.ref_div = div_set[`DIV_MSB:0];
		next_s.pll_a_pd = (div_set[`DIV_MSB:0] == 7'h00);
		next_s.shutdown = full_sd & pin_req;
		next_s.pll_suspend = ~s.regs[`ADDR_PLLSUS][`PSUS_MSB:0] |
			{4{next_s.shutdown}};
		next_s.ref_clk = s.regs[`ADDR_REFSRC][`REFSRC_BIT];
		next_s.trim = s.regs[`ADDR_TRIM][`TRIM_MSB:0];
	end

	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			s <= reset_state();
		end else if (I_CE) begin
			s <= next_s;
		end
	end

	// ==========================================
	// output suspend control
	output_suspend_ctl #(
		.NUM_OUT(`NUM_OUT)
	) u_sus (
		.i_clock(I_CLOCK),
		.i_rst(I_RST),
		.i_ce(I_CE),
		.i_force_n(s.regs[`ADDR_OFORCE][6:0]),
		.i_enable(s.regs[`ADDR_OSUS_EN][6:0]),
		.i_pin_req(pin_req),
		.i_full_shutdown(full_sd),
		.i_style(I_OUTPUT_DISABLE_STYLE),
		.o_suspend(sus),
		.o_tristate(tri_st)
	);

	assign O_SDA = s.sda_out;
	assign O_SDA_OE = s.sda_oe;
	assign O_USE_SW_SELECT = s.use_sw;
	assign O_ACTIVE_CONFIG = s.active_cfg;
	assign O_OUTPUT_SUSPEND = sus;
	assign O_OUTPUT_TRISTATE = tri_st;
	assign O_PLL_SUSPEND = s.pll_suspend;
	assign O_SHUTDOWN = s.shutdown;
	assign O_REF_FROM_INPUT_CLOCK = s.ref_clk;
	assign O_CRYSTAL_TRIM = s.trim;
	assign O_PLL_A_ZERO_CAP = s.zero_cap;
	assign O_PLL_A_PUMP_CURRENT = s.pump;
	assign O_PLL_A_ZERO_RES = s.zero_res;
	assign O_PLL_A_REF_DIV = s.ref_div;
	assign O_PLL_A_POWER_DOWN = s.pll_a_pd;

	// ==========================================
	// checks
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);

	property p_hw_mode;
		I_CE && !s.regs[`ADDR_MODE][`MODE_BIT] |=>
			O_ACTIVE_CONFIG == $past(sel_pins) && !O_USE_SW_SELECT;
	endproperty
	a_hw_mode: assert property (p_hw_mode)
		else $error("hardware mode ignores select pins");
	property p_sw_mode;
		I_CE && s.regs[`ADDR_MODE][`MODE_BIT] |=>
			O_ACTIVE_CONFIG == $past(s.regs[`ADDR_CFGSEL][`SEL_MSB:0]);
	endproperty
	a_sw_mode: assert property (p_sw_mode)
		else $error("software mode ignores select field");
	property p_pll_suspend;
		I_CE && !full_sd |=>
			O_PLL_SUSPEND == ~$past(s.regs[`ADDR_PLLSUS][`PSUS_MSB:0]);
	endproperty
	a_pll_suspend: assert property (p_pll_suspend)
		else $error("pll suspend does not follow register");
	property p_shutdown;
		I_CE |=> O_SHUTDOWN == ($past(full_sd) && $past(pin_req));
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown option not honoured");
	property p_ref_source;
		I_CE |=> O_REF_FROM_INPUT_CLOCK ==
			$past(s.regs[`ADDR_REFSRC][`REFSRC_BIT]);
	endproperty
	a_ref_source: assert property (p_ref_source)
		else $error("reference source mismatch");
	property p_trim;
		I_CE |=> O_CRYSTAL_TRIM == $past(s.regs[`ADDR_TRIM][`TRIM_MSB:0]);
	endproperty
	a_trim: assert property (p_trim)
		else $error("crystal trim mismatch");
	property p_ref_div;
		I_CE && s.regs[`ADDR_MODE][`MODE_BIT] &&
			s.regs[`ADDR_CFGSEL][`SEL_MSB:0] == 3'h1 |=>
			O_PLL_A_REF_DIV == $past(s.regs[`ADDR_DIV1][`DIV_MSB:0]);
	endproperty
	a_ref_div: assert property (p_ref_div)
		else $error("divider of selected set not applied");
	property p_power_down;
		O_PLL_A_POWER_DOWN == (O_PLL_A_REF_DIV == 7'h00);
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("zero divider does not power down");
	property p_reserved;
		(s.regs[`ADDR_RSV6] | s.regs[`ADDR_RSV8] | s.regs[`ADDR_RSV9] |
			(s.regs[`ADDR_CFGSEL] & ~`MASK_CFGSEL) |
			(s.regs[`ADDR_OFORCE] & ~`MASK_OFORCE)) == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit holds a one");
	c_write: cover property (s.st == ST_WDATA_ACK);
	c_read: cover property (s.st == ST_RDATA_ACK && !s.nack);
	c_ignore: cover property (s.st == ST_IGNORE);
	c_sw_cfg5: cover property (O_USE_SW_SELECT && O_ACTIVE_CONFIG == 3'h5);
endmodule : clkgen_config_bank

/* File: clkgen_pkg.sv */
// clkgen_pkg: types shared by the clock generator register bank
// assumes: clkgen_cfg.svh is on the include path
package clkgen_pkg;
`include "clkgen_cfg.svh"
	typedef logic [2:0] cfg_sel_t;
	typedef logic [7:0] reg_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_PTR = 4'h3,
		ST_PTR_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RDATA_ACK = 4'h8,
		ST_IGNORE = 4'h9
	} link_state_e;
endpackage : clkgen_pkg

/* File: output_suspend_ctl.sv */
// output_suspend_ctl: per-output suspend and disable style
// assumes: all inputs come from logic on i_clock
`timescale 1ns/1ps
module output_suspend_ctl #(
	parameter int NUM_OUT = 7
) (
	input wire logic i_clock, // system clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic i_ce, // clock enable
	input wire logic [NUM_OUT-1:0] i_force_n, // force suspend, low
	input wire logic [NUM_OUT-1:0] i_enable, // pin may suspend
	input wire logic i_pin_req, // pin asks for suspend
	input wire logic i_full_shutdown, // pin acts as shutdown
	input wire logic [NUM_OUT-1:0] i_style, // 1 tristate, 0 low
	output logic [NUM_OUT-1:0] o_suspend, // output suspended
	output logic [NUM_OUT-1:0] o_tristate // suspended and floated
);
	typedef struct packed {
		logic [NUM_OUT-1:0] suspend;
		logic [NUM_OUT-1:0] tristate;
	} sus_state_s;
	sus_state_s s;
	sus_state_s next_s;
	logic [NUM_OUT-1:0] next_sus;
	logic [NUM_OUT-1:0] next_tri;

	// ==========================================
	// per-output decision
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
		// forced suspend wins over the enable bit
		assign next_sus[g] = ~i_force_n[g] |
			(i_pin_req & (i_enable[g] | i_full_shutdown));
		assign next_tri[g] = next_sus[g] & i_style[g];
	end

	always_comb begin
		next_s.suspend = next_sus;
		next_s.tristate = next_tri;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_suspend = s.suspend;
	assign o_tristate = s.tristate;

	// ==========================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_pin_suspends;
		i_ce && i_pin_req |=> (o_suspend & $past(i_enable)) == $past(i_enable);
	endproperty
	a_pin_suspends: assert property (p_pin_suspends)
		else $error("enabled output not suspended by pin");
	property p_unenabled_free;
		i_ce && !i_full_shutdown |=>
			(o_suspend & ~$past(i_enable) & $past(i_force_n)) == '0;
	endproperty
	a_unenabled_free: assert property (p_unenabled_free)
		else $error("output suspended without enable");
	property p_style;
		i_ce |=> o_tristate == (o_suspend & $past(i_style));
	endproperty
	a_style: assert property (p_style)
		else $error("suspended state ignores disable style");
	property p_force;
		i_ce |=> (~$past(i_force_n) & ~o_suspend) == '0;
	endproperty
	a_force: assert property (p_force)
		else $error("forced output not suspended");
	c_pin_suspend: cover property (i_pin_req && |o_suspend);
endmodule : output_suspend_ctl

/* File: pin_sync.sv */
// pin_sync: two-flop synchroniser for asynchronous pins
// assumes: inputs are quasi-static or slow compared to i_clock
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clock, // system clock
	input wire logic i_rst, // synchronous reset, high
	input wire logic i_ce, // clock enable
	input wire logic [WIDTH-1:0] i_async, // pin levels
	output logic [WIDTH-1:0] o_sync // synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_s;
	sync_state_s s;
	sync_state_s next_s;

	// first stage feeds only the second stage
	always_comb begin
		next_s.meta = i_async;
		next_s.stable = s.meta;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			s <= '0;
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_sync = s.stable;
endmodule : pin_sync

/* File: serial_host.sv */
// serial_host: two-wire host model that programs the register bank
// assumes: data wire resolved outside with a pull-up; paced by i_clock
`timescale 1ns/1ps
module serial_host (
	input wire logic i_clock, // bench clock, pacing only
	input wire logic i_sda, // resolved data wire level
	output logic o_scl, // serial clock, idle high
	output logic o_sda_low // 1 pulls the data wire low
);
	logic addr_ack; // address byte of the last write was acked
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		addr_ack = 1'b0;
	end
	// ========
	// bit level: eight clocks a phase, twice the minimum
	task automatic half();
		repeat (8) @(negedge i_clock);
	endtask : half
	// also serves as repeated start from a low clock
	task automatic start();
		o_sda_low = 1'b0;
		half();
		o_scl = 1'b1;
		half();
		o_sda_low = 1'b1;
		half();
		o_scl = 1'b0;
		half();
	endtask : start
	task automatic stop();
		o_sda_low = 1'b1;
		half();
		o_scl = 1'b1;
		half();
		o_sda_low = 1'b0;
		half();
	endtask : stop
	// data moves a whole phase after the clock fell, never near its edge
	task automatic xbyte(input logic [7:0] d, input logic a_in,
		output logic [7:0] q, output logic a_out);
		logic [8:0] sh;
		sh = {d, a_in};
		for (int i = 8; i >= 0; i--) begin
			o_sda_low = !sh[i];
			half();
			o_scl = 1'b1;
			half();
			sh[i] = i_sda;
			o_scl = 1'b0;
			half();
		end
		q = sh[8:1];
		a_out = sh[0];
	endtask : xbyte
	// ========
	// transfers
	task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] d[$]);
		logic [7:0] q;
		logic a;
		start();
		xbyte({dev, 1'b0}, 1'b1, q, a);
		addr_ack = !a;
		xbyte(ptr, 1'b1, q, a);
		foreach (d[i])
			xbyte(d[i], 1'b1, q, a);
		stop();
	endtask : wr
	// one byte then a nack, so the bank lets go of the wire
	task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] q);
		logic [7:0] t;
		logic a;
		start();
		xbyte({dev, 1'b0}, 1'b1, t, a);
		xbyte(ptr, 1'b1, t, a);
		start();
		xbyte({dev, 1'b1}, 1'b1, t, a);
		xbyte(8'hFF, 1'b1, q, a);
		stop();
	endtask : rd
endmodule : serial_host

/* File: tb.sv */
// tb: self-checking bench for the configuration register bank
// assumes: serial_host model; bank address from clkgen_cfg.svh
`timescale 1ns/1ps
`include "clkgen_cfg.svh"
module tb;
	import clkgen_pkg::*;
	localparam logic [7:0] RST_V [19] = '{8'h00, 8'h00, 8'h02, 8'h02,
		8'h0F, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10,
		8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] MSK [19] = '{8'h01, 8'h07, 8'hFF, 8'h7F,
		8'h8F, 8'h04, 8'h00, 8'h1F, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'h7F};
	logic clock, rst, ce, scl, sda_low, sda_oe, sda, use_sw, shut;
	logic shpin, refin, zcap, pdn, sda_drv;
	cfg_sel_t pins, act_cfg;
	logic [6:0] style, osus, otri, rdiv;
	logic [3:0] pllsus, zres;
	logic [2:0] pump;
	logic [4:0] trim;
	logic [7:0] exp_q[$], obs_q[$], wq[$], la, da;
	int mismatches, n_checks, cycles, seed_junk;
	// pull-up on the data wire; the bank pulls only with its drive value
	assign sda = !((sda_oe & !sda_drv) | sda_low);
	serial_host serial_host_inst (.i_clock(clock), .i_sda(sda),
		.o_scl(scl), .o_sda_low(sda_low));
	clkgen_config_bank clkgen_config_bank_inst (.I_CLOCK(clock),
		.I_RST(rst), .I_CE(ce), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_drv),
		.O_SDA_OE(sda_oe), .I_CFG_SEL_PINS(pins),
		.I_SHUTDOWN_ENABLE_PIN(shpin), .I_OUTPUT_DISABLE_STYLE(style),
		.O_USE_SW_SELECT(use_sw), .O_ACTIVE_CONFIG(act_cfg),
		.O_OUTPUT_SUSPEND(osus), .O_OUTPUT_TRISTATE(otri),
		.O_PLL_SUSPEND(pllsus), .O_SHUTDOWN(shut),
		.O_REF_FROM_INPUT_CLOCK(refin), .O_CRYSTAL_TRIM(trim),
		.O_PLL_A_ZERO_CAP(zcap), .O_PLL_A_PUMP_CURRENT(pump),
		.O_PLL_A_ZERO_RES(zres), .O_PLL_A_REF_DIV(rdiv),
		.O_PLL_A_POWER_DOWN(pdn));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// ========
	// checking
	task automatic finish_test();
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic pchk(input logic [7:0] s, input logic [7:0] e);
		exp_q.push_back(e);
		obs_q.push_back(s);
	endtask : pchk
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		exp_q.push_back(e);
		serial_host_inst.rd(`DEV_ADDR, a, q);
		obs_q.push_back(q);
	endtask : rdchk
	// margin covers two sync flops plus the output register
	task automatic settle();
		repeat (8) @(negedge clock);
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
		serial_host_inst.wr(`DEV_ADDR, a, d);
		settle();
	endtask : wr
	initial forever begin
		@(negedge clock);
		while (obs_q.size() > 0)
			chk(obs_q.pop_front(), exp_q.pop_front());
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			finish_test();
		end
	end
	// ========
	// scenarios
	initial begin
		seed_junk = $urandom(32'h9688ea34);
		rst = 1'b1;
		ce = 1'b1;
		pins = 3'h0;
		shpin = 1'b0;
		style = 7'h00;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		settle();
		for (int i = 0; i < 19; i++)
			rdchk(8'(i), RST_V[i]);
		pchk({4'h0, pllsus}, 8'h00);
		pchk({7'h0, refin}, 8'h01);
		pchk({1'b0, osus}, 8'h7D);
		pchk({7'h0, pdn}, 8'h01);
		pchk({5'h0, act_cfg}, 8'h00);
		// one byte past the map lands on the unmapped pointer
		for (int i = 0; i < 20; i++)
			wq.push_back(8'($urandom));
		wr(8'h00, wq);
		for (int i = 0; i < 19; i++)
			rdchk(8'(i), wq[i] & MSK[i]);
		rdchk(8'h13, 8'h00);
		serial_host_inst.wr(`DEV_ADDR ^ 7'h01, 8'h00, '{~wq[0]});
		pchk({7'h0, serial_host_inst.addr_ack}, 8'h00);
		rdchk(8'h00, wq[0] & 8'h01);
		wr(8'h10, '{8'h7F, 8'h00, 8'h81});
		for (int s = 0; s < 8; s++) begin
			wr(8'h00, '{8'h01, 8'(s)});
			la = (s == 4) ? wq[10] : (s == 5) ? wq[11] :
				(s < 4) ? wq[12 + s] : wq[12];
			da = (s == 1) ? 8'h00 : (s == 2) ? 8'h01 : 8'h7F;
			pchk({5'h0, act_cfg}, 8'(s));
			pchk({7'h0, use_sw}, 8'h01);
			pchk({zcap, pump, zres}, la);
			pchk({1'b0, rdiv}, da);
			pchk({7'h0, pdn}, {7'h0, da == 8'h00});
		end
		pins = 3'($urandom);
		wr(8'h00, '{8'h00});
		pchk({5'h0, act_cfg}, {5'h0, pins});
		pchk({7'h0, use_sw}, 8'h00);
		// enable low freezes the pin path and the outputs
		ce = 1'b0;
		pins = ~pins;
		settle();
		pchk({5'h0, act_cfg}, {5'h0, ~pins});
		ce = 1'b1;
		settle();
		pchk({5'h0, act_cfg}, {5'h0, pins});
		style = 7'($urandom);
		shpin = 1'b1;
		wr(8'h02, '{8'h55, 8'h7F, 8'h0A});
		pchk({1'b0, osus}, 8'h55);
		pchk({1'b0, otri}, {1'b0, style & 7'h55});
		pchk({4'h0, pllsus}, 8'h05);
		pchk({7'h0, shut}, 8'h00);
		wr(8'h03, '{8'h7D});
		pchk({1'b0, osus}, 8'h57);
		shpin = 1'b0;
		settle();
		pchk({1'b0, osus}, 8'h02);
		wr(8'h04, '{8'h8A});
		shpin = 1'b1;
		settle();
		pchk({1'b0, osus}, 8'h7F);
		pchk({4'h0, pllsus}, 8'h0F);
		pchk({7'h0, shut}, 8'h01);
		wr(8'h05, '{8'h00, 8'hFF, 8'h15});
		pchk({7'h0, refin}, 8'h00);
		pchk({3'h0, trim}, 8'h15);
		rdchk(8'h06, 8'h00);
		wr(8'h05, '{8'hFF});
		pchk({7'h0, refin}, 8'h01);
		rdchk(8'h05, 8'h04);
		repeat (2) @(negedge clock);
		finish_test();
	end
endmodule : tb
